/* File: rtl/ehr_pkg.sv */
package ehr_pkg;
  localparam int NUM_HANDLES = 6;
  localparam int HID_W = 3;
  localparam int MAX_PAYLOAD = 470;
  localparam int LEN_W = 9;
  localparam int IP_W = 32;
  localparam int PORT_W = 16;
  localparam int IO_W = 24;
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [PORT_W-1:0] DEFAULT_SLAVE_PORT = 16'h03e8;
  localparam logic [PORT_W-1:0] MODBUS_PORT = 16'h01f6;
  localparam logic [IO_W-1:0] HANDLE_WEIGHT = 24'h0003e8;
  localparam logic [IO_W-1:0] SLAVE_WEIGHT = 24'h002710;
  localparam logic [IO_W-1:0] MODULE_WEIGHT = 24'h000004;
  localparam logic [4:0] MODULE_MAX = 5'h10;
  localparam logic [2:0] BIT_MAX = 3'h4;
  localparam logic [7:0] FC_RAW = 8'hff;
  localparam logic [47:0] HW_ADDR_BASE = 48'h0200_0000_0000;
  localparam logic [HID_W-1:0] HID_NONE = 3'h0;
  localparam logic [HID_W-1:0] HID_MAX = 3'h6;
  typedef enum logic [1:0] {EHR_PROTO_NONE, EHR_PROTO_TCP, EHR_PROTO_UDP}
    ehr_proto_t;
  typedef enum logic [1:0] {EHR_DST_SERIAL, EHR_DST_HANDLE, EHR_DST_DROP}
    ehr_dst_t;
endpackage

/* File: rtl/ehr_fifo.sv */
`timescale 1ns/1ps
module ehr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign inReady = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
    ptrInc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= ptrInc(wrPtr_reg);
      end
      if (pop) begin
        rdPtr_reg <= ptrInc(rdPtr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

/* File: rtl/ehr_router.sv */
`timescale 1ns/1ps
module ehr_router (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] serialNumber,
  // connection request from a master or an open toward a slave
  input wire logic connReq,
  input wire logic connIsMaster,
  input wire ehr_pkg::ehr_proto_t connProto,
  input wire logic [ehr_pkg::PORT_W-1:0] connPort,
  input wire logic connPortGiven,
  input wire logic connModbus,
  input wire logic [ehr_pkg::HID_W-1:0] connHandle,
  input wire logic [7:0] addrB3,
  input wire logic [7:0] addrB2,
  input wire logic [7:0] addrB1,
  input wire logic [7:0] addrB0,
  input wire logic [ehr_pkg::IP_W-1:0] addrWord,
  input wire logic addrAsWord,
  output logic connAccept,
  output logic connResetPkt,
  output logic connRefused,
  output logic [ehr_pkg::HID_W-1:0] connHandleOut,
  output logic [ehr_pkg::IP_W-1:0] connIpOut,
  output logic [ehr_pkg::PORT_W-1:0] connPortOut,
  output logic [7:0] slaveAddrOut,
  // connection closing
  input wire logic closeReq,
  input wire logic [ehr_pkg::HID_W-1:0] closeHandle,
  // resets
  input wire logic hwOrSerialReset,
  input wire logic netSoftReset,
  output logic [ehr_pkg::NUM_HANDLES-1:0] handleBusy,
  // incoming packet
  input wire logic pktValid,
  input wire logic [ehr_pkg::HID_W-1:0] pktHandle,
  input wire ehr_pkg::ehr_proto_t pktProto,
  input wire logic [ehr_pkg::LEN_W:0] pktLen,
  output logic pktAck,
  output logic pktOversize,
  // response routing
  input wire logic respValid,
  input wire logic respFromProgram,
  input wire logic respHasSuffix,
  input wire logic [ehr_pkg::HID_W-1:0] respSuffixHandle,
  input wire logic default_port_select_switch,
  input wire logic [ehr_pkg::FIFO_W-1:0] respByte,
  output logic respInReady,
  output logic [ehr_pkg::FIFO_W-1:0] txByte,
  output logic txValid,
  input wire logic txReady,
  output ehr_pkg::ehr_dst_t txDst,
  output logic [ehr_pkg::HID_W-1:0] txHandle,
  output ehr_pkg::ehr_proto_t txProto,
  // modbus and io mapping
  input wire logic [7:0] funcCode,
  input wire logic mbReq,
  output logic mbOk,
  output logic mbRaw,
  input wire logic [ehr_pkg::HID_W-1:0] ioHandle,
  input wire logic [4:0] ioModule,
  input wire logic [2:0] ioBit,
  input wire logic [7:0] ioSlave,
  input wire logic ioSlaveGiven,
  output logic [ehr_pkg::IO_W-1:0] ioNumber,
  output logic [47:0] hwAddr
);
  localparam int IO_W = ehr_pkg::IO_W;
  logic [ehr_pkg::NUM_HANDLES-1:0] busy_reg;
  ehr_pkg::ehr_proto_t proto_reg [ehr_pkg::NUM_HANDLES];
  logic [ehr_pkg::NUM_HANDLES-1:0] isMaster_reg;
  logic [ehr_pkg::HID_W-1:0] lastHandle_reg;
  logic [ehr_pkg::HID_W-1:0] freeHid;
  logic [ehr_pkg::HID_W-1:0] udpMasterHid;
  logic [ehr_pkg::HID_W-1:0] grantHid;
  logic grantOk;
  logic [ehr_pkg::IP_W-1:0] ipNext;
  logic [ehr_pkg::HID_W-1:0] routeHid;
  ehr_pkg::ehr_dst_t routeDst;
  logic fifoInValid;
  logic fifoOutValid;
  logic [ehr_pkg::FIFO_W-1:0] fifoOutData;
  logic fifoOutReady;

  // handle numbers run 1..6; index 0 of the arrays is handle 1
  function automatic int hidx(input logic [ehr_pkg::HID_W-1:0] h);
    hidx = int'(h) - 1;
  endfunction

  function automatic logic hidValid(input logic [ehr_pkg::HID_W-1:0] h);
    hidValid = (h != ehr_pkg::HID_NONE) && (h <= ehr_pkg::HID_MAX);
  endfunction

  // lowest free handle, or none when the pool is exhausted
  always_comb begin
    freeHid = ehr_pkg::HID_NONE;
    udpMasterHid = ehr_pkg::HID_NONE;
    for (int i = ehr_pkg::NUM_HANDLES - 1; i >= 0; i--) begin
      if (!busy_reg[i]) begin
        freeHid = ehr_pkg::HID_W'(i + 1);
      end
      if (busy_reg[i] && isMaster_reg[i] &&
          proto_reg[i] == ehr_pkg::EHR_PROTO_UDP) begin
        udpMasterHid = ehr_pkg::HID_W'(i + 1);
      end
    end
  end

  // both address forms land in the same 32-bit word
  assign ipNext = addrAsWord ? addrWord :
                  {addrB3, addrB2, addrB1, addrB0};

  always_comb begin
    grantHid = freeHid;
    grantOk = 1'b0;
    if (connIsMaster) begin
      if (connProto == ehr_pkg::EHR_PROTO_UDP &&
          udpMasterHid != ehr_pkg::HID_NONE) begin
        grantHid = udpMasterHid;
      end
      grantOk = (connProto != ehr_pkg::EHR_PROTO_NONE) &&
                (grantHid != ehr_pkg::HID_NONE);
    end else begin
      grantHid = connHandle;
      grantOk = (connProto != ehr_pkg::EHR_PROTO_NONE) &&
                hidValid(connHandle) && !busy_reg[hidx(connHandle)];
    end
  end

  // handle pool; a network soft reset leaves it alone
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      busy_reg <= '0;
      isMaster_reg <= '0;
      for (int i = 0; i < ehr_pkg::NUM_HANDLES; i++) begin
        proto_reg[i] <= ehr_pkg::EHR_PROTO_NONE;
      end
    end else begin
      if (hwOrSerialReset) begin
        busy_reg <= '0;
      end else if (closeReq && hidValid(closeHandle)) begin
        busy_reg[hidx(closeHandle)] <= 1'b0;
      end
      // an open in the same cycle as a close or hard reset wins, so the
      // accept pulse never names a handle that was just dropped
      if (connReq && grantOk) begin
        busy_reg[hidx(grantHid)] <= 1'b1;
        isMaster_reg[hidx(grantHid)] <= connIsMaster;
        proto_reg[hidx(grantHid)] <= connProto;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      connAccept <= 1'b0;
      connResetPkt <= 1'b0;
      connRefused <= 1'b0;
      connHandleOut <= ehr_pkg::HID_NONE;
      connIpOut <= '0;
      connPortOut <= '0;
      slaveAddrOut <= '0;
    end else begin
      connAccept <= connReq && grantOk;
      connResetPkt <= connReq && connIsMaster && !grantOk;
      connRefused <= connReq && !connIsMaster && !grantOk;
      if (connReq && grantOk) begin
        connHandleOut <= grantHid;
        connIpOut <= ipNext;
        slaveAddrOut <= 8'(grantHid);
        if (connIsMaster) begin
          connPortOut <= connPort;
        end else if (connModbus) begin
          connPortOut <= ehr_pkg::MODBUS_PORT;
          slaveAddrOut <= ioSlaveGiven ? ioSlave : 8'(grantHid);
        end else begin
          connPortOut <= connPortGiven ? connPort :
                         ehr_pkg::DEFAULT_SLAVE_PORT;
        end
      end
    end
  end

  assign handleBusy = busy_reg;

  // packet intake: acknowledge only what arrived and fits
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pktAck <= 1'b0;
      pktOversize <= 1'b0;
      lastHandle_reg <= ehr_pkg::HID_NONE;
    end else begin
      pktAck <= pktValid &&
                pktLen <= (ehr_pkg::LEN_W+1)'(ehr_pkg::MAX_PAYLOAD);
      // oversize is flagged, not trusted; the sender owns the limit
      pktOversize <= pktValid &&
                pktLen > (ehr_pkg::LEN_W+1)'(ehr_pkg::MAX_PAYLOAD);
      if (pktValid && hidValid(pktHandle)) begin
        lastHandle_reg <= pktHandle;
      end
    end
  end

  always_comb begin
    routeHid = pktHandle;
    routeDst = ehr_pkg::EHR_DST_HANDLE;
    if (respHasSuffix) begin
      routeHid = respSuffixHandle;
    end else if (respFromProgram) begin
      if (default_port_select_switch) begin
        routeHid = lastHandle_reg;
      end else begin
        routeDst = ehr_pkg::EHR_DST_SERIAL;
      end
    end
    // a closed or bogus destination is dropped rather than misrouted
    if (routeDst == ehr_pkg::EHR_DST_HANDLE &&
        (!hidValid(routeHid) || !busy_reg[hidx(routeHid)])) begin
      routeDst = ehr_pkg::EHR_DST_DROP;
    end
  end

  assign fifoInValid = respValid;

  ehr_fifo #(
    .WIDTH(ehr_pkg::FIFO_W),
    .DEPTH(ehr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .inData(respByte),
    .inValid(fifoInValid),
    .inReady(respInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  // one-stage output register; holds its byte while txReady is low
  assign fifoOutReady = !txValid || txReady;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      txValid <= 1'b0;
      txByte <= '0;
    end else if (fifoOutReady) begin
      txValid <= fifoOutValid;
      txByte <= fifoOutData;
    end
  end

  // destination is latched on every byte accepted into the buffer; it follows the newest byte, not the one in txByte
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      txDst <= ehr_pkg::EHR_DST_SERIAL;
      txHandle <= ehr_pkg::HID_NONE;
      txProto <= ehr_pkg::EHR_PROTO_NONE;
    end else if (respValid && respInReady) begin
      txDst <= routeDst;
      txHandle <= routeHid;
      txProto <= hidValid(routeHid) ? proto_reg[hidx(routeHid)] :
                 pktProto;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mbOk <= 1'b0;
      mbRaw <= 1'b0;
    end else begin
      mbRaw <= mbReq && funcCode == ehr_pkg::FC_RAW;
      mbOk <= mbReq && ((funcCode >= 8'h01 && funcCode <= 8'h07) ||
              (funcCode >= 8'h0f && funcCode <= 8'h11));
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ioNumber <= '0;
    end else begin
      ioNumber <= IO_W'(ioHandle) * ehr_pkg::HANDLE_WEIGHT
                + IO_W'(ioModule - 5'h01) * ehr_pkg::MODULE_WEIGHT
                + IO_W'(ioBit - 3'h1)
                + (ioSlaveGiven ? IO_W'(ioSlave) * ehr_pkg::SLAVE_WEIGHT
                   : '0);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hwAddr <= ehr_pkg::HW_ADDR_BASE;
    end else begin
      hwAddr <= {ehr_pkg::HW_ADDR_BASE[47:16], serialNumber};
    end
  end
endmodule

/* File: verif/ehr_router_props.sv */
`timescale 1ns/1ps
module ehr_router_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] serialNumber,
  input wire logic connReq,
  input wire logic connIsMaster,
  input wire ehr_pkg::ehr_proto_t connProto,
  input wire logic connResetPkt,
  input wire logic connRefused,
  input wire logic hwOrSerialReset,
  input wire logic [5:0] handleBusy,
  input wire logic pktValid,
  input wire logic [9:0] pktLen,
  input wire logic pktAck,
  input wire logic pktOversize,
  input wire logic mbReq,
  input wire logic [7:0] funcCode,
  input wire logic mbOk,
  input wire logic mbRaw,
  input wire logic [47:0] hwAddr
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // a udp master may still join the shared handle, so only tcp is checked for refusal
  sequence s_full_tcp;
    handleBusy == 6'h3f && connReq && connIsMaster &&
      connProto == ehr_pkg::EHR_PROTO_TCP;
  endsequence
  sequence s_slave_no_proto;
    connReq && !connIsMaster && connProto == ehr_pkg::EHR_PROTO_NONE;
  endsequence
  AST_FULL_RESET_PKT: assert property (s_full_tcp |=> connResetPkt)
    else $error("full pool gave no reset packet");
  AST_SLAVE_NO_PROTO: assert property (s_slave_no_proto |=> connRefused)
    else $error("slave open without protocol not refused");
  AST_HW_RESET_FREES: assert property (
    hwOrSerialReset && !connReq |=> handleBusy == 6'h00)
    else $error("handles kept after hard reset");
  AST_PKT_ACK: assert property (
    pktValid && pktLen <= 10'h1d6 |=> pktAck && !pktOversize)
    else $error("legal packet not acknowledged");
  AST_PKT_OVERSIZE: assert property (
    pktValid && pktLen > 10'h1d6 |=> pktOversize && !pktAck)
    else $error("oversize packet not flagged");
  AST_MB_OK: assert property (
    mbReq && funcCode inside {[8'h01:8'h07], [8'h0f:8'h11]} |=> mbOk)
    else $error("supported function code rejected");
  AST_MB_RAW: assert property (mbReq && funcCode == 8'hff |=> mbRaw)
    else $error("raw function code not taken");
  AST_HW_ADDR: assert property (
    $past(reset_n) |-> hwAddr[15:0] == $past(serialNumber))
    else $error("hardware address low bytes differ from serial");
endmodule
bind ehr_router ehr_router_props ehr_router_props_i (.*);

/* File: verif/ehr_host_model.sv */
`timescale 1ns/1ps
module ehr_host_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] txByte,
  input wire logic txValid,
  input wire logic hold,
  input wire logic slow,
  output logic txReady,
  output logic [7:0] lastByte,
  output int rxCount
);
  // slow drains every other cycle so the stream must hold its byte
  always_ff @(posedge mclk) begin
    if (!reset_n)
      txReady <= 1'b0;
    else
      txReady <= !hold && (!slow || !txReady);
  end
  always_ff @(posedge mclk) begin
    if (!reset_n)
      rxCount <= 0;
    else if (txValid && txReady) begin
      rxCount <= rxCount + 1;
      lastByte <= txByte;
    end
  end
endmodule

/* File: verif/test_ehr_router.sv */
`timescale 1ns/1ps
module test_ehr_router;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] serialNumber = 16'h4a5b;
  logic connReq, connIsMaster, connPortGiven, connModbus, addrAsWord;
  logic closeReq, hwOrSerialReset, netSoftReset, pktValid, respValid;
  logic respFromProgram, respHasSuffix, default_port_select_switch;
  logic mbReq, ioSlaveGiven, connAccept, connResetPkt, connRefused;
  logic pktAck, pktOversize, respInReady, txValid, txReady, mbOk, mbRaw;
  ehr_pkg::ehr_proto_t connProto, pktProto, txProto;
  ehr_pkg::ehr_dst_t txDst;
  logic [15:0] connPort, connPortOut;
  logic [2:0] connHandle, connHandleOut, closeHandle, pktHandle;
  logic [2:0] respSuffixHandle, txHandle, ioHandle, ioBit;
  logic [7:0] addrB3, addrB2, addrB1, addrB0, slaveAddrOut, respByte;
  logic [7:0] txByte, funcCode, ioSlave, lastByte;
  logic [31:0] addrWord, connIpOut;
  logic [5:0] handleBusy;
  logic [9:0] pktLen;
  logic [4:0] ioModule;
  logic [23:0] ioNumber;
  logic [47:0] hwAddr;
  logic hold = 1'b1;
  logic slow = 1'b0;
  int rxCount, failures = 0, tests_run = 0;

  ehr_router ehr_router_i (.*);
  ehr_host_model ehr_host_model_i (.*);

  always #2 mclk = ~mclk;

  task automatic chk(string n, logic [47:0] e, logic [47:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task final_report;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // every task starts and ends just after a falling edge
  // an idle cycle first: back-to-back strobes never toggle in one step
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask

  task conn(logic m, ehr_pkg::ehr_proto_t p, logic [2:0] h);
    connIsMaster = m;
    connProto = p;
    connHandle = h;
    pulse(connReq);
  endtask

  task t_pool;
    for (int i = 1; i <= 5; i++) begin
      conn(1'b1, ehr_pkg::EHR_PROTO_TCP, 3'h0);
      chk("count", i, $countones(handleBusy));
    end
    conn(1'b1, ehr_pkg::EHR_PROTO_UDP, 3'h0);
    conn(1'b1, ehr_pkg::EHR_PROTO_UDP, 3'h0);
    chk("udp join", 1, connAccept);
    chk("busy", 6'h3f, handleBusy);
    conn(1'b1, ehr_pkg::EHR_PROTO_TCP, 3'h0);
    chk("reset pkt", 1, connResetPkt);
    closeHandle = 3'h3;
    pulse(closeReq);
    chk("closed", 6'h3b, handleBusy);
    connPort = 16'h1f90;
    conn(1'b1, ehr_pkg::EHR_PROTO_TCP, 3'h0);
    chk("reuse", 3'h3, connHandleOut);
    chk("master port", 16'h1f90, connPortOut);
    pulse(netSoftReset);
    chk("net reset", 6'h3f, handleBusy);
    pulse(hwOrSerialReset);
    chk("hard reset", 6'h00, handleBusy);
  endtask

  task t_slave;
    {addrB3, addrB2, addrB1, addrB0} = 32'h9719ff09;
    addrWord = 32'h9719ff09;
    conn(1'b0, ehr_pkg::EHR_PROTO_TCP, 3'h2);
    chk("ip bytes", 32'h9719ff09, connIpOut);
    chk("port dflt", 16'h03e8, connPortOut);
    addrB3 = 8'h00;
    addrAsWord = 1'b1;
    connPortGiven = 1'b1;
    connPort = 16'h00b3;
    conn(1'b0, ehr_pkg::EHR_PROTO_TCP, 3'h3);
    chk("ip word", 32'h9719ff09, connIpOut);
    chk("port", 16'h00b3, connPortOut);
    connModbus = 1'b1;
    conn(1'b0, ehr_pkg::EHR_PROTO_TCP, 3'h4);
    chk("mb port", 16'h01f6, connPortOut);
    chk("mb slave", 8'h04, slaveAddrOut);
    ioSlave = 8'h21;
    ioSlaveGiven = 1'b1;
    conn(1'b0, ehr_pkg::EHR_PROTO_TCP, 3'h5);
    chk("mb addr", 8'h21, slaveAddrOut);
    ioSlaveGiven = 1'b0;
    connModbus = 1'b0;
    conn(1'b0, ehr_pkg::EHR_PROTO_NONE, 3'h5);
    chk("no proto", 1, connRefused);
    conn(1'b0, ehr_pkg::EHR_PROTO_TCP, 3'h2);
    chk("busy slot", 1, connRefused);
  endtask

  task t_misc;
    pktHandle = 3'h2;
    pktProto = ehr_pkg::EHR_PROTO_TCP;
    pktLen = 10'h1d6;
    pulse(pktValid);
    chk("ack", 1, pktAck);
    pktLen = 10'h1d7;
    pulse(pktValid);
    chk("oversize", 2'b10, {pktOversize, pktAck});
    for (int c = 0; c < 256; c++) begin
      funcCode = c[7:0];
      pulse(mbReq);
      chk("mb ok", c inside {[1:7], [15:17]}, mbOk);
      chk("mb raw", c == 255, mbRaw);
    end
    ioHandle = 3'h2;
    ioModule = 5'h10;
    ioBit = 3'h4;
    @(negedge mclk);
    chk("io", 24'h00080f, ioNumber);
    ioSlave = 8'h05;
    ioSlaveGiven = 1'b1;
    @(negedge mclk);
    chk("io slave", 24'h00cb5f, ioNumber);
  endtask

  task send(logic [7:0] b, ehr_pkg::ehr_dst_t d, logic [2:0] h);
    respByte = b;
    pulse(respValid);
    for (int i = 0; i < 40 && txValid !== 1'b1; i++) @(negedge mclk);
    if (txValid !== 1'b1) begin
      failures++;
      $display("BAD txValid expected 1 seen %b", txValid);
      final_report();
    end
    chk("dst", d, txDst);
    chk("byte", b, txByte);
    if (d == ehr_pkg::EHR_DST_HANDLE)
      chk("tx handle", h, txHandle);
    for (int i = 0; i < 40 && txValid !== 1'b0; i++) @(negedge mclk);
    if (txValid !== 1'b0) begin
      failures++;
      $display("BAD txValid expected 0 seen %b", txValid);
      final_report();
    end
  endtask

  task t_route;
    int k;
    hold = 1'b0;
    respHasSuffix = 1'b1;
    respSuffixHandle = 3'h3;
    send(8'h41, ehr_pkg::EHR_DST_HANDLE, 3'h3);
    respSuffixHandle = 3'h6;
    send(8'h42, ehr_pkg::EHR_DST_DROP, 3'h0);
    respHasSuffix = 1'b0;
    respFromProgram = 1'b1;
    send(8'h43, ehr_pkg::EHR_DST_SERIAL, 3'h0);
    default_port_select_switch = 1'b1;
    send(8'h44, ehr_pkg::EHR_DST_HANDLE, 3'h2);
    chk("proto", ehr_pkg::EHR_PROTO_TCP, txProto);
    respFromProgram = 1'b0;
    send(8'h45, ehr_pkg::EHR_DST_HANDLE, 3'h2);
    hold = 1'b1;
    k = 0;
    // buffer plus output register should swallow five bytes, no more
    for (int i = 0; i < 10; i++) begin
      respByte = 8'h10 + k[7:0];
      respValid = 1'b1;
      if (respInReady === 1'b1)
        k++;
      @(negedge mclk);
    end
    respValid = 1'b0;
    chk("held", 5, k);
    hold = 1'b0;
    slow = 1'b1;
    for (int i = 0; i < 80 && rxCount < 10; i++) @(negedge mclk);
    chk("received", 10, rxCount);
    chk("last", 8'h14, lastByte);
  endtask

  initial begin
    {connReq, connIsMaster, connPortGiven, connModbus, addrAsWord} = '0;
    {closeReq, hwOrSerialReset, netSoftReset, pktValid, respValid} = '0;
    {respFromProgram, respHasSuffix, default_port_select_switch} = '0;
    {mbReq, ioSlaveGiven, connPort, connHandle, closeHandle} = '0;
    {pktHandle, respSuffixHandle, ioHandle, ioBit, ioModule} = '0;
    {addrB3, addrB2, addrB1, addrB0, respByte, funcCode, ioSlave} = '0;
    {addrWord, pktLen} = '0;
    connProto = ehr_pkg::EHR_PROTO_NONE;
    pktProto = ehr_pkg::EHR_PROTO_NONE;
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk("hw addr", serialNumber, hwAddr[15:0]);
    chk("idle", 6'h00, handleBusy);
    t_pool();
    t_slave();
    t_misc();
    t_route();
    final_report();
  end
endmodule
